// [hdl/sccb_pkg.sv]
package sccb_pkg;
  // Serial clock timing: 33.33 ns minimum period, expressed in ps
  localparam int SCLK_PERIOD_PS = 33330;
  localparam int MCLK_PERIOD_PS = 50000;
  // Least half period rounds up to whole cycles, never below one
  localparam int SCLK_HALF_CYC_RAW = (SCLK_PERIOD_PS / 2 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_CYC_RAW < 1) ? 1 : SCLK_HALF_CYC_RAW;
  // Flash read command and start addresses of the two images
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam int ADDR_W = 24;
  localparam int CMD_BITS = 32;
  // Default image lengths in bits
  localparam logic [31:0] IMG_BITS_DEF = 32'h0000_0040;
  localparam logic [23:0] IMG1_ADDR_DEF = 24'h00_0000;
  localparam logic [23:0] IMG2_ADDR_DEF = 24'h01_0000;
  // Loader states
  typedef enum logic [2:0]
  {
    SCCB_IDLE = 3'b000,
    SCCB_CMD = 3'b001,
    SCCB_OWN = 3'b010,
    SCCB_GAP = 3'b011,
    SCCB_BCAST = 3'b100,
    SCCB_WAIT_DONE = 3'b101,
    SCCB_INIT = 3'b110
  } sccb_state_t;
endpackage

// [hdl/sccb_sync.sv]
// Two-flop synchroniser for pin inputs, one per bit
module sccb_sync
  import sccb_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins in, synchronised out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // First stage is read only by the second stage
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_out <= meta_r;
    end
  end
endmodule

// [hdl/sccb_master.sv]
module sccb_master
  import sccb_pkg::*;
#(
  parameter logic [31:0] IMG1_BITS = IMG_BITS_DEF,
  parameter logic [31:0] IMG2_BITS = IMG_BITS_DEF,
  parameter logic [23:0] IMG1_ADDR = IMG1_ADDR_DEF,
  parameter logic [23:0] IMG2_ADDR = IMG2_ADDR_DEF
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic two_image,
  // Flash side
  output logic config_serial_clock,
  output logic flash_select_n,
  output logic flash_command_out,
  input wire logic flash_data_in,
  // Chain side
  output logic chain_enable_n,
  output logic slave_data_out,
  // Shared open-drain done line
  input wire logic load_complete_line_in,
  output logic load_complete_line_out,
  output logic load_complete_line_oe,
  // Status
  output logic own_loaded,
  output logic own_bit_valid,
  output logic own_bit,
  output logic init_start
);
  initial
  begin
    if (IMG1_BITS == 32'h0 || IMG2_BITS == 32'h0)
      $error("sccb_master: image lengths must be nonzero");
  end

  logic [1:0] pins_s;
  logic data_s;
  logic done_s;
  sccb_state_t state_r;
  logic [7:0] div_r;
  logic sclk_r;
  logic fall_en;
  logic [31:0] cnt_r;
  logic [CMD_BITS-1:0] cmd_r;
  logic bcast_r;
  logic cap_own_r;
  logic cap_any_r;

  sccb_sync #(.W(2)) u_sync
  (
    .mclk(mclk),
    .rst(rst),
    .pin_in({flash_data_in, load_complete_line_in}),
    .sync_out(pins_s)
  );
  assign data_s = pins_s[1];
  assign done_s = pins_s[0];

  // Clock divider; the falling edge is the one-cycle enable that moves the link
  // Held low until select has settled low, so the flash never sees a rise with select
  assign fall_en = sclk_r && (div_r == 8'(SCLK_HALF_CYC - 1));
  always_ff @(posedge mclk)
  begin
    if (rst || flash_select_n || state_r == SCCB_IDLE || state_r == SCCB_GAP || state_r == SCCB_WAIT_DONE ||
        state_r == SCCB_INIT)
    begin
      div_r <= 8'h00;
      sclk_r <= 1'b0;
    end
    else if (div_r == 8'(SCLK_HALF_CYC - 1))
    begin
      div_r <= 8'h00;
      sclk_r <= ~sclk_r;
    end
    else
      div_r <= div_r + 8'h01;
  end
  assign config_serial_clock = sclk_r;

  // Loader sequence: command, own image, then in two-image mode a second command and broadcast of the second copy
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= SCCB_IDLE;
      cnt_r <= 32'h0;
      cmd_r <= '0;
      bcast_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        SCCB_IDLE:
        begin
          if (start)
          begin
            state_r <= SCCB_CMD;
            cnt_r <= 32'(CMD_BITS - 1);
            cmd_r <= {FLASH_READ_CMD, IMG1_ADDR};
            bcast_r <= 1'b0;
          end
        end
        SCCB_CMD:
        begin
          if (fall_en)
          begin
            cmd_r <= {cmd_r[CMD_BITS-2:0], 1'b0};
            if (cnt_r == 32'h0)
            begin
              state_r <= bcast_r ? SCCB_BCAST : SCCB_OWN;
              cnt_r <= (bcast_r ? IMG2_BITS : IMG1_BITS) - 32'h1;
            end
            else
              cnt_r <= cnt_r - 32'h1;
          end
        end
        SCCB_OWN:
        begin
          if (fall_en)
          begin
            if (cnt_r == 32'h0)
              state_r <= two_image ? SCCB_GAP : SCCB_WAIT_DONE;
            else
              cnt_r <= cnt_r - 32'h1;
          end
        end
        SCCB_GAP:
        begin
          // Restart the read at the second image; select rises between reads
          state_r <= SCCB_CMD;
          cnt_r <= 32'(CMD_BITS - 1);
          cmd_r <= {FLASH_READ_CMD, IMG2_ADDR};
          bcast_r <= 1'b1;
        end
        SCCB_BCAST:
        begin
          if (fall_en)
          begin
            if (cnt_r == 32'h0)
              state_r <= SCCB_WAIT_DONE;
            else
              cnt_r <= cnt_r - 32'h1;
          end
        end
        SCCB_WAIT_DONE:
        begin
          if (done_s)
            state_r <= SCCB_INIT;
        end
        SCCB_INIT:
          state_r <= SCCB_INIT;
        default:
          state_r <= SCCB_IDLE;
      endcase
    end
  end

  // Pin outputs, launched and captured on the falling serial edge
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      flash_select_n <= 1'b1;
      flash_command_out <= 1'b0;
      slave_data_out <= 1'b0;
      own_bit_valid <= 1'b0;
      own_bit <= 1'b0;
      cap_own_r <= 1'b0;
      cap_any_r <= 1'b0;
    end
    else
    begin
      flash_select_n <= !(state_r == SCCB_CMD || state_r == SCCB_OWN || state_r == SCCB_BCAST);
      // First command bit is set up before the first rise, the rest change on the fall
      if (state_r == SCCB_CMD)
      begin
        if (fall_en)
          flash_command_out <= (cnt_r == 32'h0) ? 1'b0 : cmd_r[CMD_BITS-2];
      end
      else if ((state_r == SCCB_IDLE && start) || state_r == SCCB_GAP)
        flash_command_out <= FLASH_READ_CMD[7];
      else
        flash_command_out <= 1'b0;
      // Synchroniser delays the pin by two cycles; the sample is taken one cycle after the fall
      cap_own_r <= fall_en && state_r == SCCB_OWN;
      cap_any_r <= fall_en && (state_r == SCCB_OWN || state_r == SCCB_BCAST);
      own_bit_valid <= cap_own_r;
      if (cap_own_r)
        own_bit <= data_s;
      if (cap_any_r)
        slave_data_out <= data_s;
    end
  end

  // Chain enable and done line; single image leaves enable high as a spare pin
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      chain_enable_n <= 1'b1;
      own_loaded <= 1'b0;
      load_complete_line_out <= 1'b0;
      load_complete_line_oe <= 1'b1;
      init_start <= 1'b0;
    end
    else
    begin
      if (state_r == SCCB_GAP)
        chain_enable_n <= 1'b0;
      else if (state_r == SCCB_IDLE)
        chain_enable_n <= 1'b1;
      if (state_r == SCCB_OWN && fall_en && cnt_r == 32'h0)
        own_loaded <= 1'b1;
      // Hold the line low until all own data and any broadcast are out
      load_complete_line_oe <= !(state_r == SCCB_WAIT_DONE || state_r == SCCB_INIT);
      load_complete_line_out <= 1'b0;
      init_start <= state_r == SCCB_WAIT_DONE && done_s;
    end
  end
endmodule

// [test/sccb_flash_model.sv]
module sccb_flash_model(
  // Serial link from the master
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic cmd_in,
  // Data back, last command seen
  output logic dout,
  output logic [31:0] cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // Command bits latched on the rising serial edge
  always @(posedge sclk)
    if (!sel_n)
    begin
      if (n < 32) cmd <= {cmd[30:0], cmd_in};
      n <= n + 1;
    end
  // One flash feeds the chain; address bit 16 tells the two copies apart
  always @(negedge sclk)
    if (!sel_n && n >= 32) dout <= n[0] ^ n[3] ^ cmd[16];
  // Released data line shows the inverse, never a stale bit
  always @(posedge sel_n)
  begin
    n <= 0;
    dout <= ~dout;
  end
  initial dout = 1'b0;
endmodule

// [test/sccb_master_chk.sv]
module sccb_master_chk(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched ports
  input wire logic config_serial_clock,
  input wire logic flash_select_n,
  input wire logic flash_command_out,
  input wire logic chain_enable_n,
  input wire logic load_complete_line_in,
  input wire logic load_complete_line_out,
  input wire logic load_complete_line_oe,
  input wire logic own_loaded,
  input wire logic init_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Done line seen high through the synchroniser, own drive released
  sequence done_seen;
    $past(load_complete_line_in, 3) && !load_complete_line_oe;
  endsequence
  hold_chain_a: assert property (!own_loaded |-> chain_enable_n) else $error("chain enable early");
  chain_after_a: assert property ($fell(chain_enable_n) |-> own_loaded) else $error("chain before load");
  clk_still_a: assert property (flash_select_n && $past(flash_select_n) |-> !config_serial_clock)
    else $error("clock outside frame");
  clk_run_a: assert property (!flash_select_n && !$past(flash_select_n) |-> $changed(config_serial_clock))
    else $error("clock stalled");
  cmd_fall_a: assert property ($changed(flash_command_out) && !flash_select_n |-> $fell(config_serial_clock))
    else $error("command not on falling edge");
  done_free_a: assert property ($fell(load_complete_line_oe) |-> own_loaded) else $error("done released early");
  init_cause_a: assert property (init_start |-> done_seen) else $error("init without done");
  init_pulse_a: assert property (init_start |=> !init_start) else $error("init not a pulse");
  od_low_a: assert property (load_complete_line_oe |-> !load_complete_line_out) else $error("done driven high");
endmodule
bind sccb_master sccb_master_chk u_chk(.mclk, .rst, .config_serial_clock, .flash_select_n, .flash_command_out,
  .chain_enable_n, .load_complete_line_in, .load_complete_line_out, .load_complete_line_oe, .own_loaded, .init_start);

// [test/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sccb_pkg::*;
  logic mclk, rst, start, two_image, slave_hold;
  logic sclk, sel_n, cmd_o, fdat, cen_n, sdo, done_in, done_out, done_oe, loaded, bv, bit_o, init;
  logic [31:0] cmd;
  int n_errors, compares, nbits, k;
  // Rows: mode, chain enable at end, last command seen
  logic [33:0] rows [2] = '{{2'b01, FLASH_READ_CMD, IMG1_ADDR_DEF}, {2'b10, FLASH_READ_CMD, IMG2_ADDR_DEF}};
  sccb_master #(.IMG1_BITS(32'h10), .IMG2_BITS(32'h10)) u_dut(.mclk, .rst, .start, .two_image,
    .config_serial_clock(sclk), .flash_select_n(sel_n), .flash_command_out(cmd_o), .flash_data_in(fdat),
    .chain_enable_n(cen_n), .slave_data_out(sdo), .load_complete_line_in(done_in),
    .load_complete_line_out(done_out), .load_complete_line_oe(done_oe), .own_loaded(loaded),
    .own_bit_valid(bv), .own_bit(bit_o), .init_start(init));
  // One flash; the slaves appear only as slave_hold on the done line
  sccb_flash_model u_flash(.sclk, .sel_n, .cmd_in(cmd_o), .dout(fdat), .cmd);
  // Pulled-up done line; a slave still loading holds it low
  assign done_in = !(done_oe && !done_out) && !slave_hold;
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (exp !== got)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_init(int lim);
    k = 0;
    while (init !== 1'b1 && k < lim)
    begin
      @(negedge mclk);
      k++;
    end
  endtask
  task automatic run(logic mode);
    @(posedge mclk);
    rst <= 1'b1;
    two_image <= mode;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    nbits = 0;
    @(posedge mclk) start <= 1'b1;
    @(posedge mclk) start <= 1'b0;
    wait_init(600);
  endtask
  // Own image bits arrive in flash order, one per serial clock
  always @(posedge mclk)
    if (bv === 1'b1)
    begin
      check("own_bit", 32'(nbits[0] ^ nbits[3]), 32'(bit_o));
      check("slave_bit", 32'(nbits[0] ^ nbits[3]), 32'(sdo));
      nbits++;
    end
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    #300us;
    n_errors++;
    complete_run();
  end
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    two_image = 1'b0;
    slave_hold = 1'b0;
    foreach (rows[i])
    begin
      run(rows[i][33]);
      check("init", 32'h1, 32'(init));
      check("bits", 32'h10, 32'(nbits));
      check("cmd", rows[i][31:0], cmd);
      check("chain_n", 32'(rows[i][32]), 32'(cen_n));
    end
    // Slave not finished: nobody may start initialisation
    @(posedge mclk) slave_hold <= 1'b1;
    run(1'b1);
    check("init_held", 32'h0, 32'(init));
    @(posedge mclk) slave_hold <= 1'b0;
    wait_init(8);
    check("init_late", 32'h1, 32'(init));
    complete_run();
  end
endmodule
